// *** pcs_pkg.sv ***
package pcs_pkg;

  // ***********************************************************
  // Register map (byte addresses, one aligned word each)
  // ***********************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;  // Current options, writable
  localparam logic [7:0] ADDR_PWRON   = 8'h04;  // Stored power-on options
  localparam logic [7:0] ADDR_SETS    = 8'h08;  // Primary/secondary set ids
  localparam logic [7:0] ADDR_YOFF    = 8'h0C;  // Graphics vertical offset
  localparam logic [7:0] ADDR_IFCFG   = 8'h10;  // Interface settings
  localparam logic [7:0] ADDR_STATUS  = 8'h14;  // Live state
  localparam logic [7:0] ADDR_CMD     = 8'h18;  // Command strobes

  // ***********************************************************
  // Option bit positions (CTRL and PWRON)
  // ***********************************************************
  localparam int OPT_HIGHBIT = 0;  // High-bit select mode
  localparam int OPT_LATCH   = 1;  // Permanent set latching
  localparam int OPT_TRANSP  = 2;  // Transparent print mode
  localparam int OPT_W       = 3;

  // Interface config bits
  localparam int IF_EXTADDR = 0;  // Extended addressing
  localparam int IF_SRQ     = 1;  // Service request
  localparam int IF_LISTEN  = 2;  // Always receive
  localparam int IF_W       = 3;

  // Command bits
  localparam int CMD_RESTORE = 0;  // Restore all defaults
  localparam int CMD_SAVE    = 1;  // Copy current options to power-on

  // ***********************************************************
  // Reset and default values
  // ***********************************************************
  localparam logic [OPT_W-1:0] OPT_DEFAULT = 3'h2;  // Latch on, others off
  localparam logic [IF_W-1:0]  IF_DEFAULT  = 3'h2;  // Service request on
  localparam logic [7:0]  SET_PRI_DEFAULT  = 8'h00;  // US ASCII id
  localparam logic [7:0]  SET_SEC_DEFAULT  = 8'h01;  // Extended Latin id
  localparam logic [9:0]  YOFF_MAX         = 10'h3E7;  // 999
  localparam logic [15:0] PARAM_MAX        = 16'h270F; // 9999

  // ***********************************************************
  // Stream codes
  // ***********************************************************
  localparam logic [7:0] CH_SO  = 8'h0E;
  localparam logic [7:0] CH_SI  = 8'h0F;
  localparam logic [7:0] CH_LF  = 8'h0A;
  localparam logic [7:0] CH_CR  = 8'h0D;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_Y   = 8'h59;  // Transparent on
  localparam logic [7:0] CH_Z   = 8'h5A;  // Transparent off
  localparam logic [7:0] CH_AMP = 8'h26;
  localparam logic [7:0] CH_STAR= 8'h2A;
  localparam logic [7:0] CH_LPAR= 8'h28;
  localparam logic [7:0] CH_RPAR= 8'h29;
  localparam logic [7:0] CH_K   = 8'h6B;
  localparam logic [7:0] CH_R   = 8'h72;
  localparam logic [7:0] CH_I   = 8'h49;
  localparam logic [7:0] CH_F   = 8'h46;
  localparam logic [7:0] CH_YU  = 8'h59;  // Offset terminator
  localparam logic [7:0] CH_MIN = 8'h2D;
  localparam logic [7:0] CH_D0  = 8'h30;

  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 8;

endpackage : pcs_pkg

// *** pcs_fifo.sv ***
module pcs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] in_data,    // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,   // Drain side, registered
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];  // Storage
  logic [AW-1:0] wp;           // Write pointer
  logic [AW-1:0] rp;           // Read pointer
  logic [AW:0]   cnt;          // Words held including output stage
  logic [AW:0]   held;         // Words in memory only

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  wire load = (held != '0) && (!out_valid || out_ready);

  // Full counts the output register too, so depth is honest
  assign in_ready = (cnt != (AW+1)'(DEPTH));

  // Memory write
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // Pointers and counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp   <= '0;
      rp   <= '0;
      held <= '0;
      cnt  <= '0;
    end else begin
      if (push) wp <= AW'(wp + 1'b1);
      if (load) rp <= AW'(rp + 1'b1);
      held <= (AW+1)'(held + push - load);
      cnt  <= (AW+1)'(cnt + push - pop);
    end
  end

  // Registered read data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rp];
    end else if (pop) begin
      out_valid <= 1'b0;
    end
  end
endmodule : pcs_fifo

// *** pcs_charset.sv ***
// Notes on behaviour
// - Vertical offset held 0..999, default 0.
// - Offset parameter limited to plus/minus 9999.
// - Escape assigns primary set, default ASCII.
// - Escape assigns secondary set, default Latin.
// - Shift-out selects secondary, shift-in primary.
// - Shift and high-bit modes exclude each other.
// - High-bit mode: top bit picks set.
// - High-bit control positions are dropped.
// - High-bit plus transparent: underline seven-bit char.
// - Without latching, each line starts primary.
// - Escape codes toggle latching, default on.
// - Interface settings persist until changed.
// - Extended addressing forces service, receive off.
// - Restore loads defaults everywhere.
// - Transparent mode prints controls, few exceptions.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
module pcs_charset
  import pcs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Host byte stream
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  // Printable output
  output logic [6:0]       pr_char,
  output logic             pr_secondary,
  output logic             pr_underline,
  output logic             pr_valid,
  input  wire logic        pr_ready,
  output logic             pr_newline,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ***********************************************************
  // State
  // ***********************************************************
  typedef enum logic [2:0] {
    PCS_IDLE, PCS_ESC, PCS_GROUP, PCS_NUM, PCS_SETID
  } pcs_state_e;

  pcs_state_e  st;            // Escape parser state
  logic [7:0]  grp;           // Char after ESC (& * ( )), or after & or * the next char (k or r)
  logic [15:0] num;           // Parameter magnitude
  logic        neg;           // Parameter sign
  logic        num_ovf;       // Magnitude exceeded 9999
  logic [OPT_W-1:0] opt;      // Current options
  logic [OPT_W-1:0] pwron;    // Power-on options, kept across soft reset
  logic [IF_W-1:0]  ifcfg;    // Interface settings
  logic [7:0]  set_pri;       // Primary set id
  logic [7:0]  set_sec;       // Secondary set id
  logic [9:0]  yoff;          // Graphics vertical offset
  logic        shifted;       // Shift-out seen, secondary active
  logic        pwron_valid = 1'b0;  // Power-on store initialised, clear at configuration

  // ***********************************************************
  // Input buffering
  // ***********************************************************
  logic [7:0] fb;        // Byte at FIFO head
  logic       fb_valid;
  logic       fb_ready;

  pcs_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (fb),
    .out_valid (fb_valid),
    .out_ready (fb_ready)
  );

  // ***********************************************************
  // Byte classification
  // ***********************************************************
  wire        hb_mode  = opt[OPT_HIGHBIT];
  wire        transp   = opt[OPT_TRANSP];
  wire [6:0]  low7     = fb[6:0];
  wire        is_ctl7  = (low7 < 7'h20) || (low7 == 7'h7F);
  wire        is_digit = (fb >= CH_D0) && (fb <= 8'h39);
  wire        in_idle  = (st == PCS_IDLE);
  // Transparent mode executes only ESC Z and CR; the byte after ESC still prints
  wire        tr_esc   = transp && (st == PCS_ESC);
  wire        exec_esc = in_idle && (fb == CH_ESC);
  wire        is_eol   = (fb == CH_LF) || (fb == CH_CR);
  wire        hb_undef = hb_mode && fb[7] && is_ctl7 && !transp;
  // A byte produces printable output
  wire        emits    = (in_idle || tr_esc) && !hb_undef &&
                         (transp || !(is_ctl7 || fb == CH_ESC));
  wire        take     = fb_valid && fb_ready;

  // Clamp a signed parameter into 0..999
  function automatic logic [9:0] clamp_off(input logic n, input logic [15:0] m);
    if (n)
      clamp_off = '0;
    else if (m > 16'(YOFF_MAX))
      clamp_off = YOFF_MAX;
    else
      clamp_off = m[9:0];
  endfunction : clamp_off

  // ***********************************************************
  // AXI4-Lite slave
  // ***********************************************************
  logic        aw_got, w_got;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire   wr_go  = aw_got && w_got && !s_axi_bvalid;
  wire   wr_hit = (aw_q == ADDR_CTRL) || (aw_q == ADDR_PWRON) || (aw_q == ADDR_SETS) ||
                  (aw_q == ADDR_YOFF) || (aw_q == ADDR_IFCFG) || (aw_q == ADDR_CMD);
  wire   wr_ok  = wr_go && wr_hit && ws_q[0];
  wire   cmd_restore = wr_ok && (aw_q == ADDR_CMD) && w_q[CMD_RESTORE];
  wire   cmd_save    = wr_ok && (aw_q == ADDR_CMD) && w_q[CMD_SAVE];

  // Output stage stalls the stream when busy; a landing register
  // write also holds it, so neither update is lost to the other
  assign fb_ready = !(emits && pr_valid && !pr_ready) && !wr_ok;

  // Write address/data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_q   <= '0;
      w_q    <= '0;
      ws_q   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_q   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_q   <= s_axi_wdata;
        ws_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
      end
    end
  end

  // Write response; unmapped gives SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL:   rd_mux = {29'h0, opt};
      ADDR_PWRON:  rd_mux = {29'h0, pwron};
      ADDR_SETS:   rd_mux = {16'h0, set_sec, set_pri};
      ADDR_YOFF:   rd_mux = {22'h0, yoff};
      ADDR_IFCFG:  rd_mux = {29'h0, ifcfg};
      ADDR_STATUS: rd_mux = {25'h0, 3'(st), fb_valid, !rx_ready, shifted, hb_mode};
      ADDR_CMD:    rd_mux = 32'h0;
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***********************************************************
  // Escape parser
  // ***********************************************************
  // Sequences: ESC & k <n> I|F, ESC * r <n> Y, ESC ( <n><c>, ESC ) <n><c>, ESC Y, ESC Z
  wire       esc_term  = (st == PCS_NUM) && !is_digit && fb != CH_MIN;
  wire       k_seq     = (grp == CH_K);
  wire       r_seq     = (grp == CH_R);
  wire       set_term  = (st == PCS_SETID) && !is_digit;
  wire [7:0] set_code  = {num[3:0], fb[3:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st      <= PCS_IDLE;
      grp     <= '0;
      num     <= '0;
      neg     <= 1'b0;
      num_ovf <= 1'b0;
    end else if (take) begin
      unique case (st)
        PCS_IDLE: begin
          // ESC still watched for ESC Z when transparent
          if (exec_esc) st <= PCS_ESC;
        end
        PCS_ESC: begin
          num     <= '0;
          neg     <= 1'b0;
          num_ovf <= 1'b0;
          grp     <= fb;
          // transparent: nothing but ESC Z is executed
          if (transp) st <= (fb == CH_ESC) ? PCS_ESC : PCS_IDLE;
          else if (fb == CH_AMP || fb == CH_STAR) st <= PCS_GROUP;
          else if (fb == CH_LPAR || fb == CH_RPAR) st <= PCS_SETID;
          else st <= PCS_IDLE;
        end
        PCS_GROUP: begin
          grp <= fb;
          st  <= (fb == CH_K || fb == CH_R) ? PCS_NUM : PCS_IDLE;
        end
        PCS_NUM, PCS_SETID: begin
          if (fb == CH_MIN && st == PCS_NUM) begin
            neg <= 1'b1;
          end else if (is_digit) begin
            if (num > 16'h0F9F) num_ovf <= 1'b1;
            else begin
              num <= 16'(num * 16'h000A + {12'h0, fb[3:0]});
              if (16'(num * 16'h000A + {12'h0, fb[3:0]}) > PARAM_MAX) num_ovf <= 1'b1;
            end
          end else begin
            st <= PCS_IDLE;
          end
        end
        default: st <= PCS_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // Options, sets, offset, interface settings
  // ***********************************************************
  // Escape-set options are ignored while transparent
  wire esc_in_tr = transp;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opt     <= pwron_valid ? pwron : OPT_DEFAULT;
      set_pri <= SET_PRI_DEFAULT;
      set_sec <= SET_SEC_DEFAULT;
      yoff    <= '0;
    end else if (!pwron_valid) begin
      // Store not yet loaded, so its content is not trusted
      opt <= OPT_DEFAULT;
    end else if (cmd_restore) begin
      opt     <= OPT_DEFAULT;
      set_pri <= SET_PRI_DEFAULT;
      set_sec <= SET_SEC_DEFAULT;
      yoff    <= '0;
    end else if (wr_ok && aw_q == ADDR_CTRL) begin
      opt <= w_q[OPT_W-1:0];
    end else if (wr_ok && aw_q == ADDR_SETS) begin
      set_pri <= w_q[7:0];
      set_sec <= w_q[15:8];
    end else if (wr_ok && aw_q == ADDR_YOFF) begin
      yoff <= clamp_off(1'b0, {6'h0, w_q[9:0]});
    end else if (take) begin
      // ESC Z leaves transparent mode and is also printed
      if (st == PCS_ESC && fb == CH_Z) opt[OPT_TRANSP] <= 1'b0;
      if (st == PCS_ESC && fb == CH_Y && !transp) opt[OPT_TRANSP] <= 1'b1;
      if (esc_term && k_seq && !esc_in_tr && !num_ovf) begin
        if (fb == CH_I) opt[OPT_HIGHBIT] <= (num == 16'h1);
        if (fb == CH_F) opt[OPT_LATCH] <= (num == 16'h1);
      end
      if (esc_term && r_seq && fb == CH_YU && !num_ovf)
        yoff <= clamp_off(neg, num);
      if (set_term && grp == CH_LPAR) set_pri <= set_code;
      if (set_term && grp == CH_RPAR) set_sec <= set_code;
    end
  end

  // Power-on store: survives soft reset, as nonvolatile model
  always_ff @(posedge aclk) begin
    if (!pwron_valid) begin
      pwron       <= OPT_DEFAULT & ~(OPT_W'(1) << OPT_TRANSP);
      ifcfg       <= IF_DEFAULT;
      pwron_valid <= 1'b1;
    end else if (cmd_restore) begin
      pwron <= OPT_DEFAULT;
      ifcfg <= IF_DEFAULT;
    end else if (cmd_save || (wr_ok && aw_q == ADDR_PWRON)) begin
      // Transparent mode cannot be made a power-on setting
      pwron <= (cmd_save ? opt : w_q[OPT_W-1:0]) & ~(OPT_W'(1) << OPT_TRANSP);
    end else if (wr_ok && aw_q == ADDR_IFCFG) begin
      ifcfg <= w_q[IF_W-1:0];
      if (w_q[IF_EXTADDR]) begin
        ifcfg[IF_SRQ]    <= 1'b0;
        ifcfg[IF_LISTEN] <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // Active set tracking
  // ***********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shifted <= 1'b0;
    end else if (take && in_idle && !transp && !hb_mode) begin
      if (fb == CH_SO) shifted <= 1'b1;
      else if (fb == CH_SI) shifted <= 1'b0;
      else if (fb == CH_LF && !opt[OPT_LATCH]) shifted <= 1'b0;
    end
  end

  // ***********************************************************
  // Printable output register
  // ***********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pr_valid     <= 1'b0;
      pr_char      <= '0;
      pr_secondary <= 1'b0;
      pr_underline <= 1'b0;
      pr_newline   <= 1'b0;
    end else begin
      pr_newline <= take && in_idle && is_eol && (!transp || fb == CH_CR);
      if (take && emits) begin
        pr_valid <= 1'b1;
        pr_char  <= low7;
        // top bit picks set in high-bit mode
        pr_secondary <= hb_mode ? (fb[7] && !transp) : shifted;
        pr_underline <= hb_mode && transp && fb[7];
      end else if (pr_ready) begin
        pr_valid <= 1'b0;
      end
    end
  end

endmodule : pcs_charset

// *** pcs_charset_monitor.sv ***
module pcs_charset_monitor
  import pcs_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [6:0] pr_char,
  input wire logic       pr_secondary,
  input wire logic       pr_underline,
  input wire logic       pr_valid,
  input wire logic       pr_ready,
  input wire logic       rx_ready,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready
);
  // ************************************
  // Checks on one clock domain
  // ************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_print_hold: assert property (
    pr_valid && !pr_ready |=> pr_valid && $stable({pr_char, pr_secondary, pr_underline}))
    else $error("printed character changed before it was taken");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while one is pending");
  chk_b_single: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_single: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  chk_rresp_code: assert property (
    s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
    else $error("read response code illegal");
  chk_underline_primary: assert property (
    pr_valid && pr_underline |-> !pr_secondary)
    else $error("underlined character marked secondary");
  // Reset itself must quiet the outputs, so this one is never disabled
  chk_reset_quiet: assert property (
    disable iff (1'b0) !aresetn |=> !pr_valid && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");

  cover property (pr_valid && pr_ready && pr_secondary);
  cover property (pr_valid && pr_underline);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (!rx_ready);
endmodule : pcs_charset_monitor

bind pcs_charset pcs_charset_monitor chk_u (.*);

// *** pcs_host_model.sv ***
module pcs_host_model (
  input  wire logic       aclk,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rx_valid = 1'b0;
  initial rx_data = 8'hA5;
  // Hold the byte until taken; afterwards the line shows the inverse, not a stale copy
  task automatic send(input logic [7:0] b);
    rx_data  <= b;
    rx_valid <= 1'b1;
    do @(posedge aclk); while (!rx_ready);
    rx_valid <= 1'b0;
    rx_data  <= ~b;
    @(posedge aclk);
  endtask : send
endmodule : pcs_host_model

// *** printer_charset_selector_bench.sv ***
module printer_charset_selector_bench;
  import pcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************
  // Signals
  // ************************************
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        stall = 1'b1;        // Printer side held off
  logic        pr_ready = 1'b0;
  logic [7:0]  rx_data;
  logic        rx_valid, rx_ready;
  logic [6:0]  pr_char;
  logic        pr_secondary, pr_underline, pr_valid, pr_newline;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;  // Whole words only
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [9:0]  e;                   // {care_sec, sec, underline, char}
  logic [9:0]  exp_q[$];
  int          failures = 0, checked = 0, nl = 0;

  always #20 aclk = ~aclk;
  pcs_charset    dut_u (.*);
  pcs_host_model host_u (.*);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rdv(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rdv

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr = 2'h0);
    logic [31:0] v;
    logic [1:0]  rs;
    rdv(a, v, rs);
    check(rs, xr);
    if (xr == 2'h0) check(v, x);
  endtask : rd

  // Flags per byte: '-' not printed, 'p' primary, 's' secondary, 'u' underlined
  task automatic play(input string s, input string f);
    byte c;
    for (int i = 0; i < s.len(); i++) begin
      c = s[i];
      if (i < f.len() && f[i] != "-") exp_q.push_back({f[i] != "u", f[i] == "s", f[i] == "u", c[6:0]});
      host_u.send(c);
    end
  endtask : play

  // Poll until the buffer is empty and every expected character seen
  task automatic drain;
    logic [31:0] v;
    logic [1:0]  rs;
    for (int k = 0; k < 100; k++) begin
      rdv(ADDR_STATUS, v, rs);
      if (!v[3] && exp_q.size() == 0) break;
    end
  endtask : drain

  task automatic rst;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : rst

  // Random stalls from the printer side
  always @(posedge aclk) pr_ready <= !stall && ($urandom % 4 != 0);

  // Oldest expectation against each character taken
  always @(posedge aclk) begin
    if (pr_newline) nl <= nl + 1;
    if (pr_valid && pr_ready) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h3FF;
      check({e[9] & pr_secondary, pr_underline, pr_char}, {e[9] & e[8], e[7:0]});
    end
  end

  initial begin
    #2000000;
    failures++;
    test_done;
  end

  initial begin
    string       t;
    string       ps[4] = '{"1234", "-5", "42", "10000"};
    logic [31:0] ys[4] = '{32'h3E7, 32'h0, 32'h2A, 32'h2A};
    int          n0;
    void'($urandom(72));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    stall <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(ADDR_CTRL, 32'h2);
    rd(ADDR_SETS, 32'h100);
    rd(ADDR_YOFF, 32'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1);
    check(r, 2'h2);
    $display("test defaults done");
    play("A\016B\017C", "p-s-p");
    play("\033&k0F", "");
    drain;
    rd(ADDR_CTRL, 32'h0);
    n0 = nl;
    play("\016D\nE", "-s-p");
    drain;
    check(nl - n0, 32'h1);
    play("\033&k1F\016F\nG\017", "------s-s-");
    $display("test shift done");
    play("\033&k1I", "");
    drain;
    rd(ADDR_CTRL, 32'h3);
    play("A\301\201\016B", "ps--p");
    play("\033Y\301\016\033Z\301", "--uppps");
    play("\033&k0I", "");
    drain;
    rd(ADDR_CTRL, 32'h2);
    $display("test high bit done");
    play("\033(8U\033)1E", "");
    drain;
    rd(ADDR_SETS, 32'h1585);
    for (int i = 0; i < 4; i++) begin
      play({"\033*r", ps[i], "Y"}, "");
      drain;
      rd(ADDR_YOFF, ys[i]);
    end
    $display("test sets and offset done");
    wr(ADDR_IFCFG, 32'h7);
    rd(ADDR_IFCFG, 32'h1);
    wr(ADDR_IFCFG, 32'h4);
    rst;
    rd(ADDR_IFCFG, 32'h4);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CMD, 32'h2);
    rd(ADDR_PWRON, 32'h0);
    play("\016", "");
    drain;
    rst;
    rd(ADDR_CTRL, 32'h0);
    play("H", "p");
    drain;
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_IFCFG, 32'h2);
    rd(ADDR_PWRON, 32'h2);
    rd(ADDR_CTRL, 32'h2);
    $display("test settings done");
    stall <= 1'b1;
    t = "aaaaaaaaaaaaaaaa";
    for (int i = 0; i < 16; i++) t.putc(i, 8'h61 + 8'($urandom % 26));
    fork
      play(t, "pppppppppppppppp");
    join_none
    for (int i = 0; i < 300 && rx_ready; i++) @(posedge aclk);
    check(rx_ready, 1'b0);
    stall <= 1'b0;
    wait fork;
    drain;
    check(exp_q.size(), 32'h0);
    $display("test buffer done");
    test_done;
  end
endmodule : printer_charset_selector_bench
